// ### pkg/srsm_pkg.sv
// package for the sensor reconfiguration and status monitor block
package srsm_pkg;

  // ==========================================================================
  // register indices (printed offsets are register numbers, not bytes)
  localparam logic [7:0] SRSM_IDX_MON_CFG     = 8'hc0; // 192
  localparam logic [7:0] SRSM_IDX_STAT_FIRST  = 8'hd0; // 208
  localparam logic [7:0] SRSM_IDX_STAT_LAST   = 8'hd6; // 214
  localparam logic [7:0] SRSM_IDX_BLACK_CFG   = 8'h80; // samples, auto enable
  localparam logic [7:0] SRSM_IDX_BLACK_OFS   = 8'h81;
  localparam logic [7:0] SRSM_IDX_CRC_SEED    = 8'h82;
  localparam logic [7:0] SRSM_IDX_SYNC_BLACK  = 8'h83;
  localparam logic [7:0] SRSM_IDX_SYNC_IMAGE  = 8'h84;
  localparam logic [7:0] SRSM_IDX_SYNC_CRC    = 8'h85;
  localparam logic [7:0] SRSM_IDX_SYNC_TRAIN  = 8'h86;
  localparam logic [7:0] SRSM_IDX_ROI_ACTIVE  = 8'h87;
  localparam logic [7:0] SRSM_IDX_EXPO_PEND   = 8'h88; // 88..8e pending set
  localparam int         SRSM_STAT_WORDS      = 7;

  // ==========================================================================
  // field positions
  localparam int SRSM_MON_SEL_LO   = 11;
  localparam int SRSM_MON_SEL_HI   = 13;
  localparam int SRSM_AUTO_BIT     = 15;
  localparam int SRSM_SAMPLES_HI   = 7;

  // ==========================================================================
  // reset values
  localparam logic [15:0] SRSM_RST_BLACK_CFG  = 16'h8008;
  localparam logic [15:0] SRSM_RST_BLACK_OFS  = 16'h0000;
  localparam logic [15:0] SRSM_RST_CRC_SEED   = 16'h0000;
  localparam logic [15:0] SRSM_RST_SYNC_BLACK = 16'h0015;
  localparam logic [15:0] SRSM_RST_SYNC_IMAGE = 16'h0035;
  localparam logic [15:0] SRSM_RST_SYNC_CRC   = 16'h0059;
  localparam logic [15:0] SRSM_RST_SYNC_TRAIN = 16'h03a6;
  localparam logic [15:0] SRSM_RST_MON_CFG    = 16'h0000;
  localparam logic [15:0] SRSM_RST_ZERO       = 16'h0000;
  localparam logic [31:0] SRSM_UNMAPPED_DATA  = 32'h0000_0000;

  // ==========================================================================
  // monitor selector codes
  localparam logic [2:0] SRSM_MON_OFF        = 3'h0;
  localparam logic [2:0] SRSM_MON_LEVELS     = 3'h1;
  localparam logic [2:0] SRSM_MON_INTEG      = 3'h2;
  localparam logic [2:0] SRSM_MON_XRD_LINES  = 3'h3;
  localparam logic [2:0] SRSM_MON_STARTS     = 3'h4;
  localparam logic [2:0] SRSM_MON_FIRST_LINE = 3'h5;
  localparam logic [2:0] SRSM_MON_ROT        = 3'h6;
  localparam logic [2:0] SRSM_MON_XRD_KIND   = 3'h7;

  // ==========================================================================
  // sequencer events and levels arriving from the frame timing logic
  typedef struct packed {
    logic frame_start;    // pulse
    logic rot_start;      // pulse
    logic xrd_start;      // pulse
    logic integrating;    // level
    logic rot_active;     // level
    logic xrd_active;     // level
    logic black_line;     // level
    logic dummy_line;     // level
    logic first_line;     // level
  } srsm_seq_t;

  // settings handed to the datapath
  typedef struct packed {
    logic [7:0]  black_samples;
    logic        auto_black_en;
    logic [15:0] black_offset;
    logic [15:0] crc_seed;
    logic [15:0] sync_black;
    logic [15:0] sync_image;
    logic [15:0] sync_crc;
    logic [15:0] sync_train;
    logic [15:0] roi_active;
  } srsm_cfg_t;

  typedef struct packed {
    logic two;
    logic one;
    logic zero;
  } srsm_ind_t;

endpackage : srsm_pkg

// ### design/srsm_stat_mem.sv
// status word store: pending exposure/gain set and the set in effect
`timescale 1ns/1ns
module srsm_stat_mem #(
  parameter int WORDS = 7,
  parameter int WIDTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic                     commit,
  input  wire logic [$clog2(WORDS)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_pend,
  output logic      [WIDTH-1:0]         rd_live
);
  import srsm_pkg::*;

  localparam int IW = $clog2(WORDS);

  // an index needs at least one bit, so a single word is refused
  if (WORDS < 2 || WIDTH < 1)
  begin : g_bad_params
    $error("srsm_stat_mem: WORDS must be >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] pend_reg [WORDS];
  logic [WIDTH-1:0] live_reg [WORDS];

  // ==========================================================================
  // pending and live words
  // live copy only moves on commit, so reads between frames stay coherent
  for (genvar g = 0; g < WORDS; g++)
  begin : g_word
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        pend_reg[g] <= '0;
        live_reg[g] <= '0;
      end
      else
      begin
        if (wr_en && wr_idx == IW'(g))
          pend_reg[g] <= wr_data;
        if (commit)
          live_reg[g] <= pend_reg[g];
      end
    end
  end

  // registered read ports
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_pend <= '0;
      rd_live <= '0;
    end
    else
    begin
      // indices past the last word read as zero instead of unknown
      rd_pend <= (int'(rd_idx) < WORDS) ? pend_reg[rd_idx] : '0;
      rd_live <= (int'(rd_idx) < WORDS) ? live_reg[rd_idx] : '0;
    end
  end
endmodule // srsm_stat_mem

// ### design/srsm_top.sv
// register bank, status reporting and indicator outputs of the sequencer
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

module srsm_top (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire srsm_pkg::srsm_seq_t seq,
  output srsm_pkg::srsm_cfg_t    cfg,
  output logic                   indicator_out_zero,
  output logic                   indicator_out_one,
  output logic                   indicator_out_two
);
  import srsm_pkg::*;

  localparam int IW = $clog2(SRSM_STAT_WORDS);

  typedef enum logic [1:0] {SRSM_IDLE, SRSM_READ, SRSM_DONE} srsm_bus_t;

  srsm_bus_t   bus_reg;
  srsm_bus_t   bus_next;
  logic [7:0]  idx;
  logic [15:0] wdata;
  logic        wr_hit;
  logic [15:0] mon_cfg_reg;
  logic [15:0] black_cfg_reg;
  logic [15:0] black_ofs_reg;
  logic [15:0] crc_seed_reg;
  logic [15:0] sync_black_reg;
  logic [15:0] sync_image_reg;
  logic [15:0] sync_crc_reg;
  logic [15:0] sync_train_reg;
  logic [15:0] roi_active_reg;
  logic [15:0] rd_pend;
  logic [15:0] rd_live;
  logic [7:0]  rd_idx_reg;
  logic        stat_wr;
  logic [IW-1:0] stat_widx;
  logic [IW-1:0] stat_ridx;
  logic [2:0]  mon_sel;
  srsm_ind_t   ind_next;
  srsm_ind_t   ind_reg;

  // ==========================================================================
  // avalon slave: word index from byte address, low 16 bits per lane pair
  assign idx   = avs_address[9:2];
  assign wdata = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                  avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
  // writes finish in idle, reads take a registered word; a write that
  // meets a busy read engine is stalled rather than silently dropped
  assign wr_hit = avs_write && bus_reg == SRSM_IDLE;
  assign avs_waitrequest = (avs_read && bus_reg != SRSM_DONE)
                           || (avs_write && bus_reg != SRSM_IDLE);

  // bus state: reads wait two edges for the memory read register
  always_comb
  begin
    bus_next = bus_reg;
    case (bus_reg)
      SRSM_IDLE: if (avs_read) bus_next = SRSM_READ;
      SRSM_READ: bus_next = SRSM_DONE;
      SRSM_DONE: bus_next = SRSM_IDLE;
      default:   bus_next = SRSM_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bus_reg <= SRSM_IDLE;
    else
      bus_reg <= bus_next;
  end

  // ==========================================================================
  // configuration registers; lane 0 or lane 1 enables a write, a cleared lane writes zeros
  // writes land in one edge and drive cfg directly, no frame latch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mon_cfg_reg    <= SRSM_RST_MON_CFG;
      black_cfg_reg  <= SRSM_RST_BLACK_CFG;
      black_ofs_reg  <= SRSM_RST_BLACK_OFS;
      crc_seed_reg   <= SRSM_RST_CRC_SEED;
      sync_black_reg <= SRSM_RST_SYNC_BLACK;
      sync_image_reg <= SRSM_RST_SYNC_IMAGE;
      sync_crc_reg   <= SRSM_RST_SYNC_CRC;
      sync_train_reg <= SRSM_RST_SYNC_TRAIN;
      roi_active_reg <= SRSM_RST_ZERO;
    end
    else if (wr_hit && avs_byteenable[1:0] != 2'b00)
    begin
      case (idx)
        SRSM_IDX_MON_CFG:    mon_cfg_reg    <= wdata;
        SRSM_IDX_BLACK_CFG:  black_cfg_reg  <= wdata;
        SRSM_IDX_BLACK_OFS:  black_ofs_reg  <= wdata;
        SRSM_IDX_CRC_SEED:   crc_seed_reg   <= wdata;
        SRSM_IDX_SYNC_BLACK: sync_black_reg <= wdata;
        SRSM_IDX_SYNC_IMAGE: sync_image_reg <= wdata;
        SRSM_IDX_SYNC_CRC:   sync_crc_reg   <= wdata;
        SRSM_IDX_SYNC_TRAIN: sync_train_reg <= wdata;
        SRSM_IDX_ROI_ACTIVE: roi_active_reg <= wdata; // switch after edit
        default:             ;
      endcase
    end
  end

  // settings reach the datapath without any frame gating
  always_comb
  begin
    cfg.black_samples = black_cfg_reg[SRSM_SAMPLES_HI:0];
    cfg.auto_black_en = black_cfg_reg[SRSM_AUTO_BIT];
    cfg.black_offset  = black_ofs_reg;
    cfg.crc_seed      = crc_seed_reg;
    cfg.sync_black    = sync_black_reg;
    cfg.sync_image    = sync_image_reg;
    cfg.sync_crc      = sync_crc_reg;
    cfg.sync_train    = sync_train_reg;
    cfg.roi_active    = roi_active_reg;
  end

  // ==========================================================================
  // exposure/gain: pending set written by software, live set on frame start
  assign stat_wr   = wr_hit && idx >= SRSM_IDX_EXPO_PEND
                     && idx < SRSM_IDX_EXPO_PEND + 8'(SRSM_STAT_WORDS);
  assign stat_widx = IW'(idx - SRSM_IDX_EXPO_PEND);
  assign stat_ridx = (idx >= SRSM_IDX_STAT_FIRST)
                     ? IW'(idx - SRSM_IDX_STAT_FIRST)
                     : IW'(idx - SRSM_IDX_EXPO_PEND);

  srsm_stat_mem #(
    .WORDS (SRSM_STAT_WORDS),
    .WIDTH (16)
  ) u_stat (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (stat_wr),
    .wr_idx  (stat_widx),
    .wr_data (wdata),
    .commit  (seq.frame_start),
    .rd_idx  (stat_ridx),
    .rd_pend (rd_pend),
    .rd_live (rd_live)
  );

  // latch address for the read mux stage
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_idx_reg <= 8'h00;
    else if (bus_reg == SRSM_IDLE)
      rd_idx_reg <= idx;
  end

  // read data register, valid in the done cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= SRSM_UNMAPPED_DATA;
    else if (bus_reg == SRSM_READ)
    begin
      avs_readdata <= SRSM_UNMAPPED_DATA;
      case (rd_idx_reg)
        SRSM_IDX_MON_CFG:    avs_readdata[15:0] <= mon_cfg_reg;
        SRSM_IDX_BLACK_CFG:  avs_readdata[15:0] <= black_cfg_reg;
        SRSM_IDX_BLACK_OFS:  avs_readdata[15:0] <= black_ofs_reg;
        SRSM_IDX_CRC_SEED:   avs_readdata[15:0] <= crc_seed_reg;
        SRSM_IDX_SYNC_BLACK: avs_readdata[15:0] <= sync_black_reg;
        SRSM_IDX_SYNC_IMAGE: avs_readdata[15:0] <= sync_image_reg;
        SRSM_IDX_SYNC_CRC:   avs_readdata[15:0] <= sync_crc_reg;
        SRSM_IDX_SYNC_TRAIN: avs_readdata[15:0] <= sync_train_reg;
        SRSM_IDX_ROI_ACTIVE: avs_readdata[15:0] <= roi_active_reg;
        default:
        begin
          if (rd_idx_reg >= SRSM_IDX_STAT_FIRST
              && rd_idx_reg <= SRSM_IDX_STAT_LAST)
            avs_readdata[15:0] <= rd_live;
          else if (rd_idx_reg >= SRSM_IDX_EXPO_PEND
                   && rd_idx_reg < SRSM_IDX_EXPO_PEND
                                   + 8'(SRSM_STAT_WORDS))
            avs_readdata[15:0] <= rd_pend;
        end
      endcase
    end
  end

  // ==========================================================================
  // indicator selection; one register stage, still ahead of serial data
  assign mon_sel = mon_cfg_reg[SRSM_MON_SEL_HI:SRSM_MON_SEL_LO];

  always_comb
  begin
    ind_next = '0;
    case (mon_sel)
      SRSM_MON_OFF:        ind_next = '0;
      SRSM_MON_LEVELS:
        ind_next = '{two: seq.dummy_line, one: seq.rot_active,
                     zero: seq.integrating};
      SRSM_MON_INTEG:
        ind_next = '{two: 1'b0, one: 1'b0, zero: seq.integrating};
      SRSM_MON_XRD_LINES:
        ind_next = '{two: seq.dummy_line, one: seq.black_line,
                     zero: seq.xrd_start};
      SRSM_MON_STARTS:
        ind_next = '{two: seq.xrd_start, one: seq.rot_start,
                     zero: seq.frame_start};
      SRSM_MON_FIRST_LINE:
        ind_next = '{two: !seq.rot_active, one: seq.rot_start,
                     zero: seq.first_line};
      SRSM_MON_ROT:
        ind_next = '{two: !seq.xrd_active, one: seq.xrd_start,
                     zero: seq.rot_active};
      SRSM_MON_XRD_KIND:
        ind_next = '{two: seq.xrd_start && seq.dummy_line,
                     one: seq.xrd_start && !seq.dummy_line
                          && !seq.black_line,
                     zero: seq.xrd_start && seq.black_line};
      default:             ind_next = '0;
    endcase
  end

  // registered pins; they lead the serial outputs by the link pipeline
  always_ff @(posedge clk)
  begin
    if (rst)
      ind_reg <= '0;
    else
      ind_reg <= ind_next;
  end

  assign indicator_out_zero = ind_reg.zero;
  assign indicator_out_one  = ind_reg.one;
  assign indicator_out_two  = ind_reg.two;
endmodule // srsm_top

// ### testbench/srsm_monitor.sv
// checker for bus timing, settings and indicator outputs
`timescale 1ns/1ns
module srsm_monitor
  import srsm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire srsm_seq_t   seq,
  input wire srsm_cfg_t   cfg,
  input wire logic        indicator_out_zero,
  input wire logic        indicator_out_one,
  input wire logic        indicator_out_two
);
  // ====================
  // helpers
  logic [2:0] sel_reg;
  logic [7:0] idx;
  logic       wr;
  logic [2:0] ind;
  assign idx = avs_address[9:2];
  assign wr  = avs_write && !avs_waitrequest;
  assign ind = {indicator_out_two, indicator_out_one, indicator_out_zero};
  // selector shadow; a cleared upper lane writes zeros
  always_ff @(posedge clk)
  begin
    if (rst)
      sel_reg <= SRSM_MON_OFF;
    else if (wr && idx == SRSM_IDX_MON_CFG && avs_byteenable[1:0] != 2'b00)
      sel_reg <= avs_byteenable[1] ? avs_writedata[13:11] : 3'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====================
  // assertions
  chk_ind_off_low: assert property (
    sel_reg == SRSM_MON_OFF |=> ind == 3'h0) else $error("ind not low");
  chk_ind_levels: assert property (
    sel_reg == SRSM_MON_LEVELS |=> ind == {$past(seq.dummy_line),
      $past(seq.rot_active), $past(seq.integrating)})
    else $error("level ind bad");
  chk_ind_pulses: assert property (
    sel_reg == SRSM_MON_STARTS |=> ind == {$past(seq.xrd_start),
      $past(seq.rot_start), $past(seq.frame_start)})
    else $error("pulse ind bad");
  chk_write_no_wait: assert property (
    avs_write |-> !avs_waitrequest) else $error("write stalled");
  chk_read_two_wait: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest
      ##1 !avs_waitrequest) else $error("read wait count bad");
  chk_offset_now: assert property (
    wr && idx == SRSM_IDX_BLACK_OFS && avs_byteenable[1:0] == 2'h3
      |=> cfg.black_offset == $past(avs_writedata[15:0]))
    else $error("offset late");
  chk_auto_now: assert property (
    wr && idx == SRSM_IDX_BLACK_CFG && avs_byteenable[1]
      |=> cfg.auto_black_en == $past(avs_writedata[15]))
    else $error("auto enable late");
  chk_seed_only: assert property (
    wr && idx == SRSM_IDX_CRC_SEED |=> $stable(cfg.sync_black)
      && $stable(cfg.black_offset) && $stable(cfg.black_samples))
    else $error("seed write touched others");
  chk_sync_only: assert property (
    wr && idx inside {[SRSM_IDX_SYNC_BLACK:SRSM_IDX_SYNC_TRAIN]}
      |=> $stable(cfg.crc_seed) && $stable(cfg.black_offset))
    else $error("sync write touched others");
endmodule // srsm_monitor

// ### testbench/srsm_seq_model.sv
// sequencer stand-in: a twelve-cycle frame of events while run is high
`timescale 1ns/1ns
module srsm_seq_model
  import srsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output srsm_seq_t seq
);
  logic [3:0] pos_reg;
  // frame position, parked at zero when idle
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      pos_reg <= 4'h0;
    else
      pos_reg <= (pos_reg == 4'hb) ? 4'h0 : pos_reg + 4'h1;
  end
  // events decoded from position; quiet outside frames so idle is visible
  always_comb
  begin
    seq = '0;
    if (run)
    begin
      seq.frame_start = pos_reg == 4'h0;
      seq.integrating = pos_reg < 4'h5;
      seq.rot_start   = pos_reg == 4'h5;
      seq.rot_active  = pos_reg inside {4'h5, 4'h6};
      seq.xrd_start   = pos_reg inside {4'h4, 4'h7, 4'ha};
      seq.xrd_active  = pos_reg inside {4'h4, 4'h7, 4'h8, 4'ha, 4'hb};
      seq.black_line  = pos_reg inside {[4'h7:4'h9]};
      seq.dummy_line  = pos_reg > 4'h9;
      seq.first_line  = pos_reg == 4'h4;
    end
  end
endmodule // srsm_seq_model

// ### testbench/tb.sv
// self-checking bench for the register bank and indicator outputs
`timescale 1ns/1ns
module tb;
  import srsm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        run = 1'b0;
  srsm_seq_t   seq;
  srsm_cfg_t   cfg;
  logic        ind0, ind1, ind2;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  srsm_top dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .seq(seq), .cfg(cfg), .indicator_out_zero(ind0),
    .indicator_out_one(ind1), .indicator_out_two(ind2));
  srsm_seq_model seqm (.clk(clk), .rst(rst), .run(run), .seq(seq));
  always #5 clk = ~clk;
  // ====================
  // common tasks
  task results;
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e)
    begin
      $display("CHECK FAILED %0t %s", $time, m);
      error_cnt++;
    end
  endtask
  // one transfer; request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] i, input logic [15:0] d,
           input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= b;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, 4'h3, q);
    // settings move on the accepting edge; look once they have settled
    @(negedge clk);
  endtask
  task rdc(input logic [7:0] i, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, i, 16'h0, 4'h3, q);
    chk(q, {16'h0, e}, "read data");
  endtask
  function automatic logic [2:0] exp_ind(logic [2:0] s, srsm_seq_t q);
    case (s)
      3'h1: exp_ind = {q.dummy_line, q.rot_active, q.integrating};
      3'h2: exp_ind = {2'b00, q.integrating};
      3'h3: exp_ind = {q.dummy_line, q.black_line, q.xrd_start};
      3'h4: exp_ind = {q.xrd_start, q.rot_start, q.frame_start};
      3'h5: exp_ind = {!q.rot_active, q.rot_start, q.first_line};
      3'h6: exp_ind = {!q.xrd_active, q.xrd_start, q.rot_active};
      3'h7: exp_ind = {q.xrd_start & q.dummy_line,
        q.xrd_start & !q.black_line & !q.dummy_line,
        q.xrd_start & q.black_line};
      default: exp_ind = 3'h0;
    endcase
  endfunction
  // ====================
  // scenarios
  task t_reset;
    rdc(SRSM_IDX_BLACK_CFG, SRSM_RST_BLACK_CFG);
    rdc(SRSM_IDX_SYNC_TRAIN, SRSM_RST_SYNC_TRAIN);
    rdc(SRSM_IDX_MON_CFG, SRSM_RST_MON_CFG);
    rdc(8'h3f, SRSM_UNMAPPED_DATA[15:0]);
  endtask
  task t_black;
    logic [31:0] q;
    wr(SRSM_IDX_BLACK_CFG, 16'h0004);
    chk({31'h0, cfg.auto_black_en}, 32'h0, "auto off");
    chk({24'h0, cfg.black_samples}, 32'h4, "samples");
    wr(SRSM_IDX_BLACK_OFS, 16'h0123);
    chk({16'h0, cfg.black_offset}, 32'h0123, "offset");
    bus(1'b1, SRSM_IDX_BLACK_OFS, 16'habcd, 4'h1, q);
    @(negedge clk);
    chk({16'h0, cfg.black_offset}, 32'h00cd, "lane mask");
  endtask
  task t_sync;
    wr(SRSM_IDX_CRC_SEED, 16'h5a5a);
    for (int k = 0; k < 4; k++)
      wr(SRSM_IDX_SYNC_BLACK + k[7:0], 16'h0100 + k[15:0]);
    chk({16'h0, cfg.crc_seed}, 32'h5a5a, "seed");
    chk({cfg.sync_black, cfg.sync_train}, 32'h01000103, "sync");
    chk({cfg.sync_image, cfg.sync_crc}, 32'h01010102, "sync mid");
    chk({16'h0, cfg.black_offset}, 32'h00cd, "offset kept");
    rdc(SRSM_IDX_SYNC_CRC, 16'h0102);
    // host switches to a window it prepared while another was live
    wr(SRSM_IDX_ROI_ACTIVE, 16'h0001);
    chk({16'h0, cfg.roi_active}, 32'h0001, "window switch");
  endtask
  task t_status;
    for (int k = 0; k < SRSM_STAT_WORDS; k++)
      wr(SRSM_IDX_EXPO_PEND + k[7:0], 16'h1100 + k[15:0]);
    rdc(SRSM_IDX_STAT_FIRST, SRSM_RST_ZERO);
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    for (int k = 0; k < SRSM_STAT_WORDS; k++)
      rdc(SRSM_IDX_STAT_FIRST + k[7:0], 16'h1100 + k[15:0]);
    wr(SRSM_IDX_STAT_LAST, 16'hdead);
    wr(SRSM_IDX_EXPO_PEND, 16'h2200);
    rdc(SRSM_IDX_STAT_LAST, 16'h1106);
    rdc(SRSM_IDX_STAT_FIRST, 16'h1100);
    rdc(SRSM_IDX_EXPO_PEND, 16'h2200);
    // the next frame start carries the new pending word into the live set
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    rdc(SRSM_IDX_STAT_FIRST, 16'h2200);
  endtask
  // every selector code against a running frame
  task t_indic;
    srsm_seq_t  ps;
    logic [2:0] e;
    logic [2:0] g3;
    for (int s = 0; s < 8; s++)
    begin
      wr(SRSM_IDX_MON_CFG, {2'b00, s[2:0], 11'h0});
      @(posedge clk);
      run <= 1'b1;
      // events seen in one cycle must show on the pins in the next
      @(negedge clk);
      ps = seq;
      repeat (26)
      begin
        @(negedge clk);
        e = exp_ind(s[2:0], ps);
        g3 = {ind2, ind1, ind0};
        chk(32'(g3), 32'(e), "indicator");
        ps = seq;
      end
      @(posedge clk);
      run <= 1'b0;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_black();
    t_sync();
    t_status();
    t_indic();
    results();
  end
endmodule // tb
bind srsm_top srsm_monitor mon (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .seq(seq), .cfg(cfg), .indicator_out_zero(indicator_out_zero),
  .indicator_out_one(indicator_out_one),
  .indicator_out_two(indicator_out_two));
